/* etbt_engine.sv */
// Event triggered block transfer engine with its control registers
// Contract
// - Event fetches descriptor via vector, moves, writes back
// - Block mode: high byte length, low byte counter
// - Second count word holds remaining blocks
// - Enable bit per source; bit 15 is pin interrupt zero
// - Vector base register locates vector entries
// - Enabled pin request moves one full block
// - Final transfer clears enable, request goes to CPU
// - Mode bits 7:6 value 10 selects block mode
// - Size bits 5:4 value 00 selects byte units
// - Source step bits 3:2 value 10 increments source
// - Second mode bit 4 picks block side
// - Stop bit halts module; bit 12 is engine
// - Deep stop bit gates sleep halt of bus
// - Clock fields: 000 means x8, 001 means x4
// - Vector entry holds descriptor start address
// - Block count decrements on each finished block
// - Count word 8080 gives 128 byte blocks
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
module etbt_engine #(
	parameter int SOURCES = 16
)(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Wishbone register slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [31:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Interrupt requests from the interrupt controller
	input wire logic [SOURCES-1:0] irq_req_in,
	output logic [SOURCES-1:0] cpu_irq_out,
	output logic irq_out,
	// Memory master
	output logic mem_cyc_out,
	output logic mem_we_out,
	output logic [31:0] mem_adr_out,
	output logic [3:0] mem_sel_out,
	output logic [31:0] mem_dat_out,
	input wire logic mem_ack_in,
	input wire logic [31:0] mem_dat_in,
	// Power and clock control
	input wire logic sleep_in,
	output logic deep_stop_out,
	output logic [15:0] module_stop_a_out,
	output logic [15:0] module_stop_b_out,
	output logic [15:0] module_stop_c_out,
	output logic [3:0] system_clock_mult_out,
	output logic [3:0] peripheral_clock_mult_out,
	output logic [3:0] bus_clock_mult_out,
	output logic busy_out
);
	logic [15:0] clock_ratio_select_reg;
	logic [15:0] module_stop_a_reg;
	logic [15:0] module_stop_b_reg;
	logic [15:0] module_stop_c_reg;
	logic [31:0] vector_base_reg;
	logic [SOURCES-1:0] activation_enable_first_reg;
	logic [SOURCES-1:0] pending_reg;
	logic [etbt_pkg::EV_WIDTH-1:0] irq_status_reg;
	logic [etbt_pkg::EV_WIDTH-1:0] irq_mask_reg;
	logic [31:0] wb_dat_reg;
	logic wb_ack_reg;
	etbt_pkg::etbt_state_t state_reg;
	etbt_pkg::etbt_state_t state_next;
	logic [$clog2(SOURCES)-1:0] src_sel_reg;
	logic [31:0] desc_addr_reg;
	logic [7:0] descriptor_mode_first_reg;
	logic [7:0] descriptor_mode_second_reg;
	logic [23:0] source_pointer_reg;
	logic [23:0] destination_pointer_reg;
	logic [23:0] block_start_reg;
	logic [7:0] block_length_reload_reg;
	logic [7:0] block_unit_counter_reg;
	logic [15:0] block_repeat_count_reg;
	logic [7:0] unit_data_reg;
	logic final_reg;
	logic [SOURCES-1:0] clear_enable;
	logic [SOURCES-1:0] to_cpu_reg;
	logic wb_req;
	logic wb_write;
	logic [23:0] wb_idx;
	logic start;
	logic block_mode;
	logic dst_is_block;
	logic unit_last;

	// Lowest numbered pending source wins
	function automatic logic [$clog2(SOURCES)-1:0] first_set(
		input logic [SOURCES-1:0] vec
	);
		logic [$clog2(SOURCES)-1:0] idx;
		idx = '0;
		for (int i = SOURCES - 1; i >= 0; i--)
		begin
			if (vec[i])
				idx = i[$clog2(SOURCES)-1:0];
		end
		return idx;
	endfunction

	function automatic logic [3:0] mult_decode(input logic [2:0] code);
		logic [3:0] m;
		m = 4'h0;
		if (code == etbt_pkg::MULT_CODE_X8)
			m = etbt_pkg::MULT_X8;
		else if (code == etbt_pkg::MULT_CODE_X4)
			m = etbt_pkg::MULT_X4;
		return m;
	endfunction

	// Pointer step for the two address mode bits; byte units only
	function automatic logic [23:0] step(
		input logic [23:0] ptr,
		input logic [1:0] mode
	);
		logic [23:0] p;
		p = ptr;
		if (mode == etbt_pkg::STEP_INC)
			p = ptr + 24'h000001;
		else if (mode == etbt_pkg::STEP_DEC)
			p = ptr - 24'h000001;
		return p;
	endfunction

	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0] sel
	);
		logic [15:0] v;
		v = old;
		if (sel[0])
			v[7:0] = dat[7:0];
		if (sel[1])
			v[15:8] = dat[15:8];
		return v;
	endfunction

	// Wishbone decode
	assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_reg;
	assign wb_write = wb_req & wb_we_in;
	assign wb_idx = wb_adr_in[25:2];

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			wb_ack_reg <= 1'b0;
		else
			wb_ack_reg <= wb_req;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			wb_dat_reg <= 32'h00000000;
		else if (wb_req)
		begin
			wb_dat_reg <= 32'h00000000;
			if (wb_adr_in[31:26] != 6'h00)
				wb_dat_reg <= 32'h00000000;
			else if (wb_idx == etbt_pkg::IDX_CLOCK_RATIO)
				wb_dat_reg <= {16'h0000, clock_ratio_select_reg};
			else if (wb_idx == etbt_pkg::IDX_STOP_A)
				wb_dat_reg <= {16'h0000, module_stop_a_reg};
			else if (wb_idx == etbt_pkg::IDX_STOP_B)
				wb_dat_reg <= {16'h0000, module_stop_b_reg};
			else if (wb_idx == etbt_pkg::IDX_STOP_C)
				wb_dat_reg <= {16'h0000, module_stop_c_reg};
			else if (wb_idx == etbt_pkg::IDX_VECTOR_BASE)
				wb_dat_reg <= vector_base_reg;
			else if (wb_idx == etbt_pkg::IDX_ACT_ENABLE)
				wb_dat_reg <= 32'(activation_enable_first_reg);
			else if (wb_idx == etbt_pkg::IDX_IRQ_STATUS)
				wb_dat_reg <= 32'(irq_status_reg);
			else if (wb_idx == etbt_pkg::IDX_IRQ_MASK)
				wb_dat_reg <= 32'(irq_mask_reg);
		end
	end

	assign wb_ack_out = wb_ack_reg;
	assign wb_dat_out = wb_dat_reg;

	function automatic logic hit(
		input logic [31:0] adr,
		input logic [23:0] idx
	);
		return adr[31:26] == 6'h00 && adr[25:2] == idx;
	endfunction

	// Clock, stop, vector base and interrupt mask registers
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			clock_ratio_select_reg <= etbt_pkg::RST_CLOCK_RATIO;
			module_stop_a_reg <= etbt_pkg::RST_STOP_A;
			module_stop_b_reg <= etbt_pkg::RST_STOP_B;
			module_stop_c_reg <= etbt_pkg::RST_STOP_C;
			vector_base_reg <= etbt_pkg::RST_VECTOR_BASE;
			irq_mask_reg <= '0;
		end
		else if (wb_write)
		begin
			if (hit(wb_adr_in, etbt_pkg::IDX_CLOCK_RATIO))
				clock_ratio_select_reg <= merge16(clock_ratio_select_reg,
					wb_dat_in, wb_sel_in);
			else if (hit(wb_adr_in, etbt_pkg::IDX_STOP_A))
				module_stop_a_reg <= merge16(module_stop_a_reg, wb_dat_in,
					wb_sel_in);
			else if (hit(wb_adr_in, etbt_pkg::IDX_STOP_B))
				module_stop_b_reg <= merge16(module_stop_b_reg, wb_dat_in,
					wb_sel_in);
			else if (hit(wb_adr_in, etbt_pkg::IDX_STOP_C))
				module_stop_c_reg <= merge16(module_stop_c_reg, wb_dat_in,
					wb_sel_in);
			else if (hit(wb_adr_in, etbt_pkg::IDX_VECTOR_BASE))
			begin
				for (int b = 0; b < 4; b++)
				begin
					if (wb_sel_in[b])
						vector_base_reg[b*8 +: 8] <= wb_dat_in[b*8 +: 8];
				end
			end
			else if (hit(wb_adr_in, etbt_pkg::IDX_IRQ_MASK))
				irq_mask_reg <= wb_dat_in[etbt_pkg::EV_WIDTH-1:0];
		end
	end

	// Activation enables: the completion clear overrides a same cycle bus write
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			activation_enable_first_reg <= '0;
		else
		begin
			if (wb_write && hit(wb_adr_in, etbt_pkg::IDX_ACT_ENABLE))
				activation_enable_first_reg <= wb_dat_in[SOURCES-1:0];
			if (|clear_enable)
				activation_enable_first_reg <=
					activation_enable_first_reg & ~clear_enable;
		end
	end

	// Pending activations; a new request beats the take
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			pending_reg <= '0;
		else
			pending_reg <= (pending_reg & ~(start
				? (SOURCES'(1) << first_set(pending_reg)) : '0))
				| (irq_req_in & activation_enable_first_reg);
	end

	// Requests not taken by the engine, or its final one, reach the CPU
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			to_cpu_reg <= '0;
		else
			to_cpu_reg <= (irq_req_in & ~activation_enable_first_reg)
				| clear_enable;
	end
	assign cpu_irq_out = to_cpu_reg;

	// Status flags; write one clears, a same cycle event wins
	always_ff @(posedge clk_in)
	begin
		logic [etbt_pkg::EV_WIDTH-1:0] ev;
		ev = '0;
		if (rst_in)
			irq_status_reg <= '0;
		else
		begin
			ev[etbt_pkg::EV_DESC_DONE] = state_reg == etbt_pkg::ST_END;
			ev[etbt_pkg::EV_CHAIN_END] = |clear_enable;
			irq_status_reg <= (irq_status_reg & ~((wb_write && hit(wb_adr_in,
				etbt_pkg::IDX_IRQ_STATUS)) ? wb_dat_in[etbt_pkg::EV_WIDTH-1:0]
				: '0)) | ev;
		end
	end
	assign irq_out = |(irq_status_reg & irq_mask_reg);

	// Engine stopped by its stop bit takes no new activation
	assign start = state_reg == etbt_pkg::ST_IDLE && |pending_reg
		&& !module_stop_a_reg[etbt_pkg::ENGINE_STOP_BIT];
	assign block_mode = descriptor_mode_first_reg[etbt_pkg::MODE_FIELD_LSB
		+: 2] == etbt_pkg::MODE_BLOCK;
	assign dst_is_block =
		!descriptor_mode_second_reg[etbt_pkg::AREA_SIDE_BIT];
	assign unit_last = !block_mode || block_unit_counter_reg == 8'h01;
	assign clear_enable = (state_reg == etbt_pkg::ST_END && final_reg)
		? (SOURCES'(1) << src_sel_reg) : '0;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			etbt_pkg::ST_IDLE:
				if (start)
					state_next = etbt_pkg::ST_VEC;
			etbt_pkg::ST_VEC:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_LD0;
			etbt_pkg::ST_LD0:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_LD1;
			etbt_pkg::ST_LD1:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_LD2;
			etbt_pkg::ST_LD2:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_RD;
			etbt_pkg::ST_RD:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_WR;
			etbt_pkg::ST_WR:
				if (mem_ack_in)
					state_next = unit_last ? etbt_pkg::ST_WB0
						: etbt_pkg::ST_RD;
			etbt_pkg::ST_WB0:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_WB1;
			etbt_pkg::ST_WB1:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_WB2;
			etbt_pkg::ST_WB2:
				if (mem_ack_in)
					state_next = etbt_pkg::ST_END;
			etbt_pkg::ST_END:
				state_next = etbt_pkg::ST_IDLE;
			default:
				state_next = etbt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			state_reg <= etbt_pkg::ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Descriptor fetch and working registers
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			src_sel_reg <= '0;
			desc_addr_reg <= 32'h00000000;
			descriptor_mode_first_reg <= 8'h00;
			descriptor_mode_second_reg <= 8'h00;
			source_pointer_reg <= 24'h000000;
			destination_pointer_reg <= 24'h000000;
			block_start_reg <= 24'h000000;
			block_length_reload_reg <= 8'h00;
			block_unit_counter_reg <= 8'h00;
			block_repeat_count_reg <= 16'h0000;
			unit_data_reg <= 8'h00;
			final_reg <= 1'b0;
		end
		else if (start)
		begin
			src_sel_reg <= first_set(pending_reg);
			final_reg <= 1'b0;
		end
		else if (mem_ack_in)
		begin
			case (state_reg)
				etbt_pkg::ST_VEC:
					desc_addr_reg <= mem_dat_in;
				etbt_pkg::ST_LD0:
				begin
					descriptor_mode_first_reg <= mem_dat_in[31:24];
					source_pointer_reg <= mem_dat_in[23:0];
				end
				etbt_pkg::ST_LD1:
				begin
					descriptor_mode_second_reg <= mem_dat_in[31:24];
					destination_pointer_reg <= mem_dat_in[23:0];
					block_start_reg <= dst_is_block_w(mem_dat_in[31:24])
						? mem_dat_in[23:0] : source_pointer_reg;
				end
				etbt_pkg::ST_LD2:
				begin
					block_length_reload_reg <= mem_dat_in[31:24];
					block_unit_counter_reg <= mem_dat_in[23:16];
					block_repeat_count_reg <= mem_dat_in[15:0];
				end
				etbt_pkg::ST_RD:
					unit_data_reg <= 8'(mem_dat_in >>
						{source_pointer_reg[1:0], 3'h0});
				etbt_pkg::ST_WR:
				begin
					source_pointer_reg <= step(source_pointer_reg,
						descriptor_mode_first_reg[etbt_pkg::SRC_STEP_LSB
						+: 2]);
					destination_pointer_reg <= step(destination_pointer_reg,
						descriptor_mode_second_reg[etbt_pkg::DST_STEP_LSB +: 2]);
					if (!block_mode)
					begin
						// Other modes move one unit per activation
						{block_length_reload_reg, block_unit_counter_reg} <=
							{block_length_reload_reg, block_unit_counter_reg}
							- 16'h0001;
						final_reg <= {block_length_reload_reg,
							block_unit_counter_reg} == 16'h0001;
					end
					else if (unit_last)
					begin
						block_unit_counter_reg <= block_length_reload_reg;
						if (dst_is_block)
							destination_pointer_reg <= block_start_reg;
						else
							source_pointer_reg <= block_start_reg;
						block_repeat_count_reg <= block_repeat_count_reg
							- 16'h0001;
						final_reg <= block_repeat_count_reg == 16'h0001;
					end
					else
						block_unit_counter_reg <= block_unit_counter_reg
							- 8'h01;
				end
				default:
					final_reg <= final_reg;
			endcase
		end
	end

	function automatic logic dst_is_block_w(input logic [7:0] mode_second);
		return !mode_second[etbt_pkg::AREA_SIDE_BIT];
	endfunction

	// Memory master, steered from registered state and pointers
	always_comb
	begin
		mem_cyc_out = 1'b1;
		mem_we_out = 1'b0;
		mem_sel_out = 4'hF;
		mem_adr_out = 32'h00000000;
		mem_dat_out = 32'h00000000;
		case (state_reg)
			etbt_pkg::ST_VEC:
				mem_adr_out = vector_base_reg + 32'(src_sel_reg)
					* etbt_pkg::VECTOR_STRIDE;
			etbt_pkg::ST_LD0:
				mem_adr_out = desc_addr_reg;
			etbt_pkg::ST_LD1:
				mem_adr_out = desc_addr_reg + etbt_pkg::DESC_WORD1;
			etbt_pkg::ST_LD2:
				mem_adr_out = desc_addr_reg + etbt_pkg::DESC_WORD2;
			etbt_pkg::ST_RD:
			begin
				mem_adr_out = {8'h00, source_pointer_reg};
				mem_sel_out = 4'(4'h1 << source_pointer_reg[1:0]);
			end
			etbt_pkg::ST_WR:
			begin
				mem_we_out = 1'b1;
				mem_adr_out = {8'h00, destination_pointer_reg};
				mem_sel_out = 4'(4'h1 << destination_pointer_reg[1:0]);
				mem_dat_out = {4{unit_data_reg}};
			end
			etbt_pkg::ST_WB0:
			begin
				mem_we_out = 1'b1;
				mem_adr_out = desc_addr_reg;
				mem_dat_out = {descriptor_mode_first_reg, source_pointer_reg};
			end
			etbt_pkg::ST_WB1:
			begin
				mem_we_out = 1'b1;
				mem_adr_out = desc_addr_reg + etbt_pkg::DESC_WORD1;
				mem_dat_out = {descriptor_mode_second_reg,
					destination_pointer_reg};
			end
			etbt_pkg::ST_WB2:
			begin
				mem_we_out = 1'b1;
				mem_adr_out = desc_addr_reg + etbt_pkg::DESC_WORD2;
				mem_dat_out = {block_length_reload_reg, block_unit_counter_reg,
					block_repeat_count_reg};
			end
			default:
				mem_cyc_out = 1'b0;
		endcase
	end

	// Power and clock control outputs
	assign deep_stop_out = sleep_in
		&& module_stop_a_reg[etbt_pkg::DEEP_STOP_BIT]
		&& (module_stop_a_reg & etbt_pkg::STOP_A_MODULES)
		== etbt_pkg::STOP_A_MODULES
		&& (module_stop_b_reg & etbt_pkg::STOP_B_MODULES)
		== etbt_pkg::STOP_B_MODULES
		&& (module_stop_c_reg & etbt_pkg::STOP_C_MODULES)
		== etbt_pkg::STOP_C_MODULES;
	assign module_stop_a_out = module_stop_a_reg;
	assign module_stop_b_out = module_stop_b_reg;
	assign module_stop_c_out = module_stop_c_reg;
	assign system_clock_mult_out = mult_decode(
		clock_ratio_select_reg[etbt_pkg::SYS_MULT_LSB +: 3]);
	assign peripheral_clock_mult_out = mult_decode(
		clock_ratio_select_reg[etbt_pkg::PER_MULT_LSB +: 3]);
	assign bus_clock_mult_out = mult_decode(
		clock_ratio_select_reg[etbt_pkg::BUS_MULT_LSB +: 3]);
	assign busy_out = state_reg != etbt_pkg::ST_IDLE;
endmodule

/* etbt_mem_model.sv */
// Memory partner answering the engine's memory master
`timescale 1ns/10ps
module etbt_mem_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Memory slave side
	input wire logic mem_cyc_in,
	input wire logic mem_we_in,
	input wire logic [31:0] mem_adr_in,
	input wire logic [3:0] mem_sel_in,
	input wire logic [31:0] mem_dat_in,
	output logic mem_ack_out,
	output logic [31:0] mem_dat_out,
	// Wait states before each answer
	input wire logic [3:0] wait_in
);
	logic [31:0] mem [logic [29:0]];
	logic [31:0] rd_reg;
	logic [3:0] cnt_reg;
	logic [31:0] w;
	// Read data is only valid with ack; inverted otherwise
	assign mem_dat_out = mem_ack_out ? rd_reg : ~rd_reg;
	always @(posedge clk_in)
	begin
		if (rst_in || mem_ack_out || !mem_cyc_in)
		begin
			mem_ack_out <= 1'b0;
			cnt_reg <= 4'h0;
			if (rst_in)
				rd_reg <= 32'h0;
		end
		else if (cnt_reg < wait_in)
			cnt_reg <= cnt_reg + 4'h1;
		else
		begin
			w = mem.exists(mem_adr_in[31:2]) ? mem[mem_adr_in[31:2]] : 32'h0;
			for (int b = 0; b < 4; b++)
				if (mem_we_in && mem_sel_in[b])
					w[8*b+:8] = mem_dat_in[8*b+:8];
			if (mem_we_in)
				mem[mem_adr_in[31:2]] = w;
			rd_reg <= w;
			mem_ack_out <= 1'b1;
		end
	end
endmodule

/* etbt_pkg.sv */
// Constants shared by the event triggered block transfer engine
package etbt_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [23:0] IDX_CLOCK_RATIO = 24'hFFFDC4;
	localparam logic [23:0] IDX_STOP_A = 24'hFFFDC8;
	localparam logic [23:0] IDX_STOP_B = 24'hFFFDCA;
	localparam logic [23:0] IDX_STOP_C = 24'hFFFDCC;
	localparam logic [23:0] IDX_VECTOR_BASE = 24'hFFFD80;
	localparam logic [23:0] IDX_ACT_ENABLE = 24'hFFFF20;
	localparam logic [23:0] IDX_IRQ_STATUS = 24'hFFFE00;
	localparam logic [23:0] IDX_IRQ_MASK = 24'hFFFE01;
	// Reset values
	localparam logic [15:0] RST_CLOCK_RATIO = 16'h0011;
	localparam logic [15:0] RST_STOP_A = 16'hEFFF;
	localparam logic [15:0] RST_STOP_B = 16'hFFFF;
	localparam logic [15:0] RST_STOP_C = 16'hFFFF;
	localparam logic [31:0] RST_VECTOR_BASE = 32'h00000000;
	// Stop register fields
	localparam int DEEP_STOP_BIT = 15;
	localparam int ENGINE_STOP_BIT = 12;
	localparam logic [15:0] STOP_A_MODULES = 16'h301B;
	localparam logic [15:0] STOP_B_MODULES = 16'h9800;
	localparam logic [15:0] STOP_C_MODULES = 16'h0703;
	// Clock ratio fields
	localparam int SYS_MULT_LSB = 8;
	localparam int PER_MULT_LSB = 4;
	localparam int BUS_MULT_LSB = 0;
	localparam logic [2:0] MULT_CODE_X8 = 3'h0;
	localparam logic [2:0] MULT_CODE_X4 = 3'h1;
	localparam logic [3:0] MULT_X8 = 4'h8;
	localparam logic [3:0] MULT_X4 = 4'h4;
	// Descriptor mode fields
	localparam int MODE_FIELD_LSB = 6;
	localparam int SIZE_FIELD_LSB = 4;
	localparam int SRC_STEP_LSB = 2;
	localparam int DST_STEP_LSB = 2;
	localparam int AREA_SIDE_BIT = 4;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] STEP_INC = 2'h2;
	localparam logic [1:0] STEP_DEC = 2'h3;
	// Descriptor and vector layout in bytes
	localparam logic [31:0] VECTOR_STRIDE = 32'h00000004;
	localparam logic [31:0] DESC_WORD1 = 32'h00000004;
	localparam logic [31:0] DESC_WORD2 = 32'h00000008;
	// Interrupt status bits
	localparam int EV_DESC_DONE = 0;
	localparam int EV_CHAIN_END = 1;
	localparam int EV_WIDTH = 2;
	typedef enum logic [10:0] {
		ST_IDLE = 11'h001,
		ST_VEC = 11'h002,
		ST_LD0 = 11'h004,
		ST_LD1 = 11'h008,
		ST_LD2 = 11'h010,
		ST_RD = 11'h020,
		ST_WR = 11'h040,
		ST_WB0 = 11'h080,
		ST_WB1 = 11'h100,
		ST_WB2 = 11'h200,
		ST_END = 11'h400
	} etbt_state_t;
endpackage

/* etbt_properties.sv */
// Port level checks on the block transfer engine
`timescale 1ns/10ps
module etbt_checker #(
	parameter int SOURCES = 16
)(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	// Memory master
	input wire logic mem_cyc_out,
	input wire logic mem_we_out,
	input wire logic [31:0] mem_adr_out,
	input wire logic [3:0] mem_sel_out,
	input wire logic [31:0] mem_dat_out,
	input wire logic mem_ack_in,
	// Status and power
	input wire logic busy_out,
	input wire logic irq_out,
	input wire logic [SOURCES-1:0] cpu_irq_out,
	input wire logic sleep_in,
	input wire logic deep_stop_out,
	input wire logic [15:0] module_stop_a_out,
	input wire logic [15:0] module_stop_b_out,
	input wire logic [15:0] module_stop_c_out,
	input wire logic [3:0] system_clock_mult_out
);
	logic deep_exp;
	assign deep_exp = module_stop_a_out[15] && sleep_in
		&& &(module_stop_a_out | ~etbt_pkg::STOP_A_MODULES)
		&& &(module_stop_b_out | ~etbt_pkg::STOP_B_MODULES)
		&& &(module_stop_c_out | ~etbt_pkg::STOP_C_MODULES);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_mem_wait;
		mem_cyc_out && !mem_ack_in;
	endsequence
	sequence s_start;
		$rose(busy_out);
	endsequence
	sequence s_vec_read;
		mem_cyc_out && !mem_we_out && mem_adr_out[1:0] == 2'h0;
	endsequence
	wb_answer_a: assert property (
		wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("register access not answered next cycle");
	ack_pulse_a: assert property (
		wb_ack_out |=> !wb_ack_out)
		else $error("register ack longer than one cycle");
	reset_state_a: assert property (disable iff (1'b0)
		rst_in |=> !wb_ack_out && !mem_cyc_out && !busy_out && !irq_out
			&& cpu_irq_out == '0 && system_clock_mult_out == 4'h8)
		else $error("outputs wrong after reset");
	mem_hold_a: assert property (
		s_mem_wait |=> mem_cyc_out && $stable(mem_adr_out)
			&& $stable(mem_we_out) && $stable(mem_sel_out)
			&& $stable(mem_dat_out))
		else $error("memory request changed before ack");
	idle_quiet_a: assert property (
		!busy_out |-> !mem_cyc_out)
		else $error("memory request while idle");
	start_vector_a: assert property (
		s_start |-> ##[0:2] s_vec_read)
		else $error("activation did not begin with a vector read");
	stop_hold_a: assert property (
		module_stop_a_out[12] && !busy_out |=> !busy_out)
		else $error("engine started while stopped");
	deep_stop_a: assert property (
		deep_stop_out == deep_exp)
		else $error("deep stop level wrong");
	byte_write_a: assert property (
		mem_cyc_out && mem_we_out |-> $onehot(mem_sel_out)
			|| mem_sel_out == 4'hF)
		else $error("write lanes neither one byte nor full word");
endmodule

bind etbt_engine etbt_checker #(.SOURCES(SOURCES)) etbt_checker_i (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in),
	.wb_ack_out(wb_ack_out),
	.mem_cyc_out(mem_cyc_out),
	.mem_we_out(mem_we_out),
	.mem_adr_out(mem_adr_out),
	.mem_sel_out(mem_sel_out),
	.mem_dat_out(mem_dat_out),
	.mem_ack_in(mem_ack_in),
	.busy_out(busy_out),
	.irq_out(irq_out),
	.cpu_irq_out(cpu_irq_out),
	.sleep_in(sleep_in),
	.deep_stop_out(deep_stop_out),
	.module_stop_a_out(module_stop_a_out),
	.module_stop_b_out(module_stop_b_out),
	.module_stop_c_out(module_stop_c_out),
	.system_clock_mult_out(system_clock_mult_out)
);

/* event_triggered_block_transfer_tb_top.sv */
// Self-checking bench for the block transfer engine
`timescale 1ns/10ps
module event_triggered_block_transfer_tb_top;
	localparam logic [31:0] VBASE = 32'h00002000;
	localparam logic [31:0] DESC = 32'h00FFB000;
	localparam logic [23:0] SRC = 24'h001000;
	localparam logic [23:0] DST = 24'hFF9000;
	localparam logic [7:0] MF = 8'h88;
	localparam logic [7:0] MS = 8'h08;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, madr, mwd, mrd;
	logic [3:0] sel = 4'h0, wait_n = 4'h0, msel, xs, xp, xb;
	logic [15:0] req = 16'h0, seen = 16'h0, cpu_irq, sa, sb, sc;
	logic ack, irq, mcyc, mwe, mack, busy, deep;
	int n_errors = 0;
	int total_checks = 0;
	etbt_engine etbt_engine_i (.clk_in(clk_in), .rst_in(rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .irq_req_in(req), .cpu_irq_out(cpu_irq),
		.irq_out(irq), .mem_cyc_out(mcyc), .mem_we_out(mwe),
		.mem_adr_out(madr), .mem_sel_out(msel), .mem_dat_out(mwd),
		.mem_ack_in(mack), .mem_dat_in(mrd), .sleep_in(sleep),
		.deep_stop_out(deep), .module_stop_a_out(sa),
		.module_stop_b_out(sb), .module_stop_c_out(sc),
		.system_clock_mult_out(xs), .peripheral_clock_mult_out(xp),
		.bus_clock_mult_out(xb), .busy_out(busy));
	etbt_mem_model etbt_mem_model_i (.clk_in(clk_in), .rst_in(rst_in),
		.mem_cyc_in(mcyc), .mem_we_in(mwe), .mem_adr_in(madr),
		.mem_sel_in(msel), .mem_dat_in(mwd), .mem_ack_out(mack),
		.mem_dat_out(mrd), .wait_in(wait_n));
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in)
		if (!rst_in)
			seen <= seen | cpu_irq;
	function automatic logic [7:0] pat(input int k);
		return 8'(k) ^ 8'h5A;
	endfunction
	function automatic logic [31:0] mword(input logic [31:0] a);
		if (etbt_mem_model_i.mem.exists(a[31:2]))
			return etbt_mem_model_i.mem[a[31:2]];
		return 32'h0;
	endfunction
	task check(input string what, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task bus(input logic [23:0] idx, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= {6'h00, idx, 2'h0};
		wdat <= d;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		check("bus ack", n < 20, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wr(input logic [23:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(idx, 1'b1, d, q);
	endtask
	task rd(input string what, input logic [23:0] idx, input logic [31:0] e);
		logic [31:0] q;
		bus(idx, 1'b0, 32'h0, q);
		check(what, q, e);
	endtask
	task fire(input int s);
		@(posedge clk_in);
		req <= 16'h0001 << s;
		@(posedge clk_in);
		req <= 16'h0;
	endtask
	task run_block;
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 100)
		begin
			@(posedge clk_in);
			n++;
		end
		check("block starts", n < 100, 1'b1);
		while (busy !== 1'b0 && n < 9000)
		begin
			@(posedge clk_in);
			n++;
		end
		check("block ends", n < 9000, 1'b1);
	endtask
	task chk_block(input int b, input logic [15:0] rem);
		int bad;
		logic [31:0] a;
		bad = 0;
		for (int k = 0; k < 128; k++)
		begin
			a = {8'h0, DST} + 32'(k);
			if (8'(mword(a) >> (8 * a[1:0])) !== pat(128 * b + k))
				bad++;
		end
		check("block data", bad, 0);
		check("guard", mword({8'h0, DST} + 128), 32'hA5A5A5A5);
		check("word0", mword(DESC), {MF, SRC + 24'(128 * b + 128)});
		check("word1", mword(DESC + 4), {MS, DST});
		check("word2", mword(DESC + 8), {16'h8080, rem});
	endtask
	task t_regs;
		rd("ratio", etbt_pkg::IDX_CLOCK_RATIO, 32'h0011);
		rd("stop a", etbt_pkg::IDX_STOP_A, 32'hEFFF);
		rd("stop c", etbt_pkg::IDX_STOP_C, 32'hFFFF);
		check("stop b c", {sb, sc}, 32'hFFFFFFFF);
		rd("unmapped", 24'h000010, 32'h0);
		check("per x4", xp, 4'h4);
		wr(etbt_pkg::IDX_CLOCK_RATIO, 32'h0100);
		check("sys x4", xs, 4'h4);
		check("bus x8", xb, 4'h8);
		wr(etbt_pkg::IDX_CLOCK_RATIO, 32'h0011);
		$display("register test done");
	endtask
	task t_stop;
		wr(etbt_pkg::IDX_VECTOR_BASE, VBASE);
		wr(etbt_pkg::IDX_ACT_ENABLE, 32'h8000);
		wr(etbt_pkg::IDX_STOP_A, 32'hFFFF);
		wr(etbt_pkg::IDX_STOP_C, 32'hFFFF);
		sleep <= 1'b1;
		fire(15);
		repeat (20) @(posedge clk_in);
		check("held busy", busy, 1'b0);
		check("deep stop", deep, 1'b1);
		wr(etbt_pkg::IDX_STOP_A, 32'h7FFF);
		check("no deep stop", deep, 1'b0);
		sleep <= 1'b0;
		wr(etbt_pkg::IDX_STOP_A, 32'hEFFF);
		run_block;
		chk_block(0, 16'h0001);
		rd("enable kept", etbt_pkg::IDX_ACT_ENABLE, 32'h8000);
		check("no cpu request", seen[15], 1'b0);
		$display("stop and first block test done");
	endtask
	task t_final;
		fire(3);
		repeat (3) @(posedge clk_in);
		check("passed on", seen[3], 1'b1);
		wait_n <= 4'h3;
		fire(15);
		run_block;
		chk_block(1, 16'h0000);
		rd("enable off", etbt_pkg::IDX_ACT_ENABLE, 32'h0);
		check("cpu request", seen[15], 1'b1);
		rd("status", etbt_pkg::IDX_IRQ_STATUS, 32'h3);
		check("irq masked", irq, 1'b0);
		wr(etbt_pkg::IDX_IRQ_MASK, 32'h3);
		@(posedge clk_in);
		check("irq on", irq, 1'b1);
		wr(etbt_pkg::IDX_IRQ_STATUS, 32'h3);
		@(posedge clk_in);
		check("irq off", irq, 1'b0);
		$display("final block test done");
	endtask
	initial
	begin
		logic [31:0] w;
		for (int j = 0; j < 64; j++)
		begin
			for (int k = 0; k < 4; k++)
				w[8*k+:8] = pat(4 * j + k);
			etbt_mem_model_i.mem[30'(SRC[23:2]) + 30'(j)] = w;
		end
		etbt_mem_model_i.mem[30'(VBASE[31:2]) + 30'd15] = DESC;
		etbt_mem_model_i.mem[DESC[31:2]] = {MF, SRC};
		etbt_mem_model_i.mem[DESC[31:2] + 30'd1] = {MS, DST};
		etbt_mem_model_i.mem[DESC[31:2] + 30'd2] = 32'h80800002;
		etbt_mem_model_i.mem[30'(DST[23:2]) + 30'd32] = 32'hA5A5A5A5;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs;
		t_stop;
		t_final;
		final_report;
	end
	initial
	begin
		repeat (30000) @(posedge clk_in);
		n_errors++;
		$display("watchdog expired");
		final_report;
	end
endmodule
